// ---- hdl/slfl_pkg.sv ----
// constants, field layouts and tables for lock detect and fastlock
// How it works
// R1: bit 15 runs detector, else power-save
// R2: bit 14 picks analogue or digital detector
// R3: bit 13 pulse unlocks and clears sticky flags
// R4: low bits meaning follows the mode bit
// R5: host writes zero to bits 12-8 analogue
// R6: discharge code picks charge rate multiple
// R7: charge code picks full charge time
// R8: loss window is 1.0/1.5/2.0 lock window
// R9: lock window code picks 7 to 100 ns
// R10: consecutive misses 1-8 drop lock
// R11: consecutive hits 1-32 raise lock
// R12: broken run restarts count, threshold toggles lock
// R13: divider update starts fastlock when enabled
// R14: timer expiry releases pin, normal current
// R15: coarse 0-7, fine 1-128 with zero 128
// R16: duration is four to coarse times fine
// R17: host writes zero to fastlock bits 15-13
// R18: each synthesizer has its own logic
// R19: fastlock current multiplier 4/8/12/16
// R20: live lock readable as status bit 7
package slfl_pkg;

  // ************************************************
  // register map and reset values
  // ************************************************
  localparam logic [7:0]  ADDR_LD1     = 8'h4F;
  localparam logic [7:0]  ADDR_FL1     = 8'h50;
  localparam logic [7:0]  ADDR_ST1     = 8'h56;
  localparam logic [7:0]  ADDR_LD2     = 8'h58;
  localparam logic [7:0]  ADDR_FL2     = 8'h59;
  localparam logic [7:0]  ADDR_ST2     = 8'h5F;
  localparam logic [15:0] LD_RESET     = 16'h0000;
  localparam logic [15:0] FL_RESET     = 16'h0000;
  localparam int          BIT_RST_LOCK = 13;
  localparam int          ST_LOCK_BIT  = 7;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CYC_PER_US    = 1000000 / CLK_PERIOD_PS;
  localparam int TIMER_W       = 22;
  localparam int LEVEL_W       = 18;

  // lock detect configuration, digital view
  typedef struct packed {
    logic       en;
    logic       mode;
    logic       rst_lock;
    logic [1:0] loss_win;
    logic [2:0] lock_win;
    logic [2:0] loss_thr;
    logic [4:0] lock_thr;
  } slfl_ldcfg_s;

  // fastlock control
  typedef struct packed {
    logic [2:0] rsvd;
    logic       en;
    logic [2:0] coarse;
    logic [6:0] fine;
    logic [1:0] cur;
  } slfl_flcfg_s;

  // one phase comparison, diff in half ns
  typedef struct packed {
    logic       valid;
    logic [9:0] diff;
  } slfl_pdcmp_s;

  // lock window in half ns
  function automatic logic [9:0] slfl_win(input logic [2:0] c);
    case (c)
      3'h0: slfl_win = 10'h00E;
      3'h1: slfl_win = 10'h014;
      3'h2: slfl_win = 10'h01E;
      3'h3: slfl_win = 10'h028;
      3'h4: slfl_win = 10'h03C;
      3'h5: slfl_win = 10'h064;
      3'h6: slfl_win = 10'h08C;
      default: slfl_win = 10'h0C8;
    endcase
  endfunction

  // rate table: charge us, or discharge multiple
  function automatic logic [9:0] slfl_rate(input logic [3:0] c);
    case (c)
      4'h0: slfl_rate = 10'h005;
      4'h1: slfl_rate = 10'h007;
      4'h2: slfl_rate = 10'h00A;
      4'h3: slfl_rate = 10'h00F;
      4'h4: slfl_rate = 10'h014;
      4'h5: slfl_rate = 10'h01E;
      4'h6: slfl_rate = 10'h032;
      4'h7: slfl_rate = 10'h046;
      4'h8: slfl_rate = 10'h064;
      4'h9: slfl_rate = 10'h096;
      4'hA: slfl_rate = 10'h0C8;
      4'hB: slfl_rate = 10'h12C;
      4'hC: slfl_rate = 10'h1F4;
      4'hD: slfl_rate = 10'h2BC;
      default: slfl_rate = 10'h3E8;
    endcase
  endfunction

endpackage

// ---- hdl/slfl_fltimer.sv ----
// fastlock timer and pin control for one synthesizer
`timescale 1ns/100ps
module slfl_fltimer (
  input  wire logic                clk_sys,
  input  wire logic                rst_sync_n,
  input  wire slfl_pkg::slfl_flcfg_s cfg,
  input  wire logic                div_update,
  output logic                     active,
  output logic                     pin_oe_n,
  output logic [4:0]               mult
);

  logic [slfl_pkg::TIMER_W-1:0] cnt_q;
  logic                         act_q;
  logic [slfl_pkg::TIMER_W-1:0] load;
  logic                         start;

  // R15: fine code zero means 128
  // R16: load is fine shifted by two per coarse step
  always_comb begin
    load = slfl_pkg::TIMER_W'({cfg.fine == 7'h00, cfg.fine});
    load = load << {cfg.coarse, 1'b0};
  end

  // R13: divider update starts fastlock only when enabled
  assign start = cfg.en & div_update;

  // R14: count down and release at expiry
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end else if (start) begin
      cnt_q <= load;
      act_q <= 1'b1;
    end else if (act_q) begin
      cnt_q <= cnt_q - 1'b1;
      act_q <= (cnt_q != slfl_pkg::TIMER_W'(1));
    end
  end

  assign active   = act_q;
  assign pin_oe_n = ~act_q;  // pin pulled low while active
  // R19: multiplier is (code+1) times four
  assign mult     = {cfg.cur + 2'h1 == 2'h0, cfg.cur + 2'h1, 2'b00};

  chk_fl_start: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R13
    start |=> act_q && !pin_oe_n) else $error("fastlock did not start");
  chk_fl_expire: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R14
    act_q && cnt_q == 1 && !start |=> !act_q && pin_oe_n)
    else $error("fastlock did not expire");
  chk_fl_cause: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R16
    $rose(act_q) |-> $past(start) && cnt_q == $past(load))
    else $error("fastlock started without update");

endmodule

// ---- hdl/slfl_top.sv ----
// lock detectors, register decode and fastlock for two synthesizers
`timescale 1ns/100ps
module slfl_top #(
  parameter int NSYN = 2
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      wr_en,
  input  wire logic [7:0]                wr_addr,
  input  wire logic [15:0]               wr_data,
  input  wire logic                      rd_en,
  input  wire logic [7:0]                rd_addr,
  output logic [7:0]                     rd_data,
  input  wire slfl_pkg::slfl_pdcmp_s [1:0] pd_cmp,
  input  wire logic [1:0]                div_update,
  output logic [1:0]                     lock,
  output logic [1:0]                     det_pwr_en,
  output logic [1:0]                     cp_fast,
  output logic [1:0][4:0]                cp_fast_mult,
  output logic [1:0]                     fl_pin_out,
  output logic [1:0]                     fl_pin_oe_n
);

  // ************************************************
  // checks and reset release
  // ************************************************
  // elaboration refuses any other synthesizer count
  if (NSYN != 2) begin : g_bad_nsyn
    $error("slfl_top serves exactly two synthesizers");
  end

  logic rst_meta_q;
  logic rst_sync_n;

  // reset released through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ************************************************
  // per synthesizer state
  // ************************************************
  slfl_pkg::slfl_ldcfg_s        ld_cfg_q [2];
  slfl_pkg::slfl_flcfg_s        fl_cfg_q [2];
  logic [1:0]                   rst_pulse_q;
  logic [1:0]                   lock_q;
  logic [1:0]                   in_st_q;
  logic [1:0]                   oo_st_q;
  logic [5:0]                   run_q [2];
  logic [slfl_pkg::LEVEL_W-1:0] level_q [2];
  logic [1:0]                   inph_q;
  logic [1:0]                   st_rd;
  logic [1:0]                   lock_d1_q;
  logic [1:0]                   edge_in;
  logic [1:0]                   edge_oo;

  genvar gi;
  // R18: one independent copy per synthesizer
  for (gi = 0; gi < 2; gi++) begin : g_syn
    localparam logic [7:0] A_LD = (gi == 0) ? slfl_pkg::ADDR_LD1 : slfl_pkg::ADDR_LD2;
    localparam logic [7:0] A_FL = (gi == 0) ? slfl_pkg::ADDR_FL1 : slfl_pkg::ADDR_FL2;
    localparam logic [7:0] A_ST = (gi == 0) ? slfl_pkg::ADDR_ST1 : slfl_pkg::ADDR_ST2;

    logic        ld_wr;
    logic        fl_wr;
    logic [9:0]  win;
    logic [11:0] loss_prod;
    logic [10:0] loss_win;
    logic [5:0]  lock_need;
    logic [5:0]  loss_need;
    logic        pv;
    logic        in_phase;
    logic        out_phase;
    logic [slfl_pkg::LEVEL_W-1:0] full;
    logic [slfl_pkg::LEVEL_W-1:0] dis;
    logic        clr;

    assign ld_wr = wr_en && wr_addr == A_LD;
    assign fl_wr = wr_en && wr_addr == A_FL;
    assign st_rd[gi] = rd_en && rd_addr == A_ST;

    // configuration writes; reset-lock bit never stored
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        ld_cfg_q[gi] <= slfl_pkg::LD_RESET;
      end else if (ld_wr) begin
        ld_cfg_q[gi] <= wr_data & ~(16'h0001 << slfl_pkg::BIT_RST_LOCK);
      end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        fl_cfg_q[gi] <= slfl_pkg::FL_RESET;
      end else if (fl_wr) begin
        fl_cfg_q[gi] <= wr_data;
      end
    end

    // R3: one-cycle reset-lock pulse from a write
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        rst_pulse_q[gi] <= 1'b0;
      end else begin
        rst_pulse_q[gi] <= ld_wr && wr_data[slfl_pkg::BIT_RST_LOCK];
      end
    end

    // ************************************************
    // lock detectors
    // ************************************************
    // R9: lock window from code
    // R8: loss window scaled by 2, 3, 4 or 5 halves
    always_comb begin
      win       = slfl_pkg::slfl_win(ld_cfg_q[gi].lock_win);
      loss_prod = 12'({2'b00, win} * (12'h002 + 12'(ld_cfg_q[gi].loss_win)));
      loss_win  = loss_prod[11:1];
    end

    // R11: lock threshold, zero means 32
    // R10: loss threshold, zero means 8
    assign lock_need = {ld_cfg_q[gi].lock_thr == 5'h00, ld_cfg_q[gi].lock_thr};
    assign loss_need = {2'b00, ld_cfg_q[gi].loss_thr == 3'h0, ld_cfg_q[gi].loss_thr};

    assign pv        = pd_cmp[gi].valid;
    assign in_phase  = pd_cmp[gi].diff <= win;
    assign out_phase = {1'b0, pd_cmp[gi].diff} > loss_win;

    // R7: full level is charge time in cycles
    // R6: discharge steps by the rate multiple
    assign full = slfl_pkg::LEVEL_W'(slfl_pkg::slfl_rate(ld_cfg_q[gi][3:0])
                  * slfl_pkg::CYC_PER_US);
    assign dis  = slfl_pkg::LEVEL_W'(slfl_pkg::slfl_rate(ld_cfg_q[gi][7:4]));

    // R1: disabled detector held cleared
    assign clr = !ld_cfg_q[gi].en || rst_pulse_q[gi];

    // R2: analogue path tracks last comparison phase
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        inph_q[gi] <= 1'b0;
      end else if (clr) begin
        inph_q[gi] <= 1'b0;
      end else if (pv) begin
        inph_q[gi] <= pd_cmp[gi].diff <= slfl_pkg::slfl_win(3'h0);
      end
    end

    // analogue capacitor level: charge by one, discharge by multiple
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        level_q[gi] <= '0;
      end else if (clr || !ld_cfg_q[gi].mode) begin
        level_q[gi] <= '0;
      end else if (inph_q[gi]) begin
        if (level_q[gi] < full) begin
          level_q[gi] <= level_q[gi] + 1'b1;
        end
      end else if (level_q[gi] > dis) begin
        level_q[gi] <= level_q[gi] - dis;
      end else begin
        level_q[gi] <= '0;
      end
    end

    // R12: digital run counter restarts on any break
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        run_q[gi] <= '0;
      end else if (clr || ld_cfg_q[gi].mode) begin
        run_q[gi] <= '0;
      end else if (pv) begin
        if (!lock_q[gi] && in_phase && run_q[gi] + 6'h01 != lock_need) begin
          run_q[gi] <= run_q[gi] + 6'h01;
        end else if (lock_q[gi] && out_phase && run_q[gi] + 6'h01 != loss_need) begin
          run_q[gi] <= run_q[gi] + 6'h01;
        end else begin
          run_q[gi] <= '0;
        end
      end
    end

    // R4: lock decided by the mode-selected detector
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        lock_q[gi] <= 1'b0;
      end else if (clr) begin
        lock_q[gi] <= 1'b0;
      end else if (ld_cfg_q[gi].mode) begin
        if (level_q[gi] >= full) begin
          lock_q[gi] <= 1'b1;
        end else if (level_q[gi] == '0) begin
          lock_q[gi] <= 1'b0;
        end
      end else if (pv) begin
        // R11: enough hits raise lock
        if (!lock_q[gi] && in_phase && run_q[gi] + 6'h01 == lock_need) begin
          lock_q[gi] <= 1'b1;
        end
        // R10: enough misses drop lock
        if (lock_q[gi] && out_phase && run_q[gi] + 6'h01 == loss_need) begin
          lock_q[gi] <= 1'b0;
        end
      end
    end

    // ************************************************
    // sticky status flags
    // ************************************************
    // sticky edge flags; set wins over read clear
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        in_st_q[gi] <= 1'b0;
        oo_st_q[gi] <= 1'b0;
      end else if (rst_pulse_q[gi]) begin
        // R3: reset lock clears both flags
        in_st_q[gi] <= 1'b0;
        oo_st_q[gi] <= 1'b0;
      end else begin
        in_st_q[gi] <= edge_in[gi] || (in_st_q[gi] && !st_rd[gi]);
        oo_st_q[gi] <= edge_oo[gi] || (oo_st_q[gi] && !st_rd[gi]);
      end
    end

    // ************************************************
    // fastlock timer
    // ************************************************
    // fastlock timer for this synthesizer
    slfl_fltimer u_fl (
      .clk_sys    (clk_sys),
      .rst_sync_n (rst_sync_n),
      .cfg        (fl_cfg_q[gi]),
      .div_update (div_update[gi]),
      .active     (cp_fast[gi]),
      .pin_oe_n   (fl_pin_oe_n[gi]),
      .mult       (cp_fast_mult[gi])
    );

    // ************************************************
    // detector assertions
    // ************************************************
    chk_rst_unlock: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R3
      rst_pulse_q[gi] |=> !lock_q[gi] && !in_st_q[gi] && !oo_st_q[gi] && !rst_pulse_q[gi])
      else $error("reset lock did not clear");

    chk_rst_quiet: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R3
      rst_pulse_q[gi] |->
        ##2 !in_st_q[gi] && !oo_st_q[gi])
      else $error("forced unlock set a status flag");

    chk_sticky_set: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R3
      !rst_pulse_q[gi] |=>
        in_st_q[gi] >= $past(edge_in[gi]) && oo_st_q[gi] >= $past(edge_oo[gi]))
      else $error("lock edge lost its status flag");

    chk_det_off: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R1
      !ld_cfg_q[gi].en |=> !lock_q[gi] && run_q[gi] == 0)
      else $error("disabled detector not idle");

    chk_dig_rise: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R11
      $rose(lock_q[gi]) && !$past(ld_cfg_q[gi].mode) |->
        $past(pv && in_phase && run_q[gi] + 6'h01 == lock_need))
      else $error("digital lock rose without threshold");

    chk_dig_fall: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R10
      $fell(lock_q[gi]) && !$past(ld_cfg_q[gi].mode) && !$past(clr) |->
        $past(pv && out_phase && run_q[gi] + 6'h01 == loss_need))
      else $error("digital lock fell without threshold");

    chk_run_break: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R12
      !ld_cfg_q[gi].mode && !lock_q[gi] && pv && !in_phase |=> run_q[gi] == 0)
      else $error("run not restarted");

    chk_loss_break: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R12
      !ld_cfg_q[gi].mode && lock_q[gi] && pv && !out_phase |=>
        run_q[gi] == 0)
      else $error("loss run not restarted");

    chk_ana_rise: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R7
      $rose(lock_q[gi]) && $past(ld_cfg_q[gi].mode) |-> $past(level_q[gi] >= full))
      else $error("analogue lock before full charge");

    chk_ana_fall: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R6
      $fell(lock_q[gi]) && $past(ld_cfg_q[gi].mode) && !$past(clr) |->
        $past(level_q[gi] == '0))
      else $error("analogue lock lost before discharge");
  end

  // ************************************************
  // lock edge detection
  // ************************************************
  // edge detection of live lock for sticky flags
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lock_d1_q <= 2'b00;
    end else begin
      // R3: forced unlock not a lost lock
      lock_d1_q <= lock_q & ~rst_pulse_q;
    end
  end

  assign edge_in = lock_q & ~lock_d1_q;
  assign edge_oo = ~lock_q & lock_d1_q;

  // ************************************************
  // status read port
  // ************************************************
  // R20: live lock on bit 7, sticky flags on bits 1-0
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_data <= 8'h00;
    end else if (st_rd[0]) begin
      rd_data <= {lock_q[0], 5'h00, in_st_q[0], oo_st_q[0]};
    end else if (st_rd[1]) begin
      rd_data <= {lock_q[1], 5'h00, in_st_q[1], oo_st_q[1]};
    end else if (rd_en) begin
      rd_data <= 8'h00;  // unmapped or write-only address
    end
  end

  // ************************************************
  // outputs and status checks
  // ************************************************
  assign lock        = lock_q;
  assign fl_pin_out  = 2'b00;  // open drain: only ever pulls low
  assign det_pwr_en  = {ld_cfg_q[1].en, ld_cfg_q[0].en};

  chk_rd_lock: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R20
    st_rd[0] |=> rd_data[slfl_pkg::ST_LOCK_BIT] == $past(lock_q[0]) && rd_data[6:2] == 0)
    else $error("status read lost lock state");

  chk_rd_second: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R20
    st_rd[1] && !st_rd[0] |=>
      rd_data == {$past(lock_q[1]), 5'h00, $past(in_st_q[1]), $past(oo_st_q[1])})
    else $error("second status read wrong");

  chk_rd_other: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R20
    rd_en && st_rd == 2'b00 |=>
      rd_data == 8'h00)
    else $error("unmapped read returned data");

endmodule

// ---- testbench/slfl_host.sv ----
// host processor model: config writes and status reads
`timescale 1ns/100ps
module slfl_host (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  rd_data,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [15:0]      wr_data,
  output logic             rd_en,
  output logic [7:0]       rd_addr
);
  // ************************************************
  // bus cycles, driven on the falling edge
  // ************************************************
  // bus idle at time zero
  initial begin
    wr_en   = 1'b0;
    wr_addr = 8'h00;
    wr_data = 16'h0000;
    rd_en   = 1'b0;
    rd_addr = 8'h00;
  end

  // one write, held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk_sys);
    wr_en   = 1'b0;
    wr_data = ~d; // stale data must not look valid
  endtask

  // lock config write with legal codes only
  task automatic wr_ld(input int s, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (v[14]) v[12:8] = 5'h00;
    if (v[14] && v[7:4] > 4'hC) v[7:4] = 4'hC;
    if (v[14] && v[3:0] == 4'hF) v[3:0] = 4'hE;
    if (!v[14] && v[12:11] == 2'h3) v[12:11] = 2'h2;
    wr(s ? slfl_pkg::ADDR_LD2 : slfl_pkg::ADDR_LD1, v);
  endtask

  // fastlock write
  task automatic wr_fl(input int s, input logic [15:0] d);
    wr(s ? slfl_pkg::ADDR_FL2 : slfl_pkg::ADDR_FL1, {3'h0, d[12:0]});
  endtask

  // one read, data taken a cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk_sys);
    rd_en   = 1'b1;
    rd_addr = a;
    @(negedge clk_sys);
    rd_en   = 1'b0;
    q       = rd_data;
  endtask
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for lock detect and fastlock
`timescale 1ns/100ps
`define CHK(got, exp, msg) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("wrong value at %0t: %s", $time, msg); \
    end \
  end
module tb;
  logic                        clk_sys;
  logic                        rst_n;
  logic                        wr_en;
  logic [7:0]                  wr_addr;
  logic [15:0]                 wr_data;
  logic                        rd_en;
  logic [7:0]                  rd_addr;
  logic [7:0]                  rd_data;
  slfl_pkg::slfl_pdcmp_s [1:0] pd_cmp;
  logic [1:0]                  div_update;
  logic [1:0]                  lock;
  logic [1:0]                  det_pwr_en;
  logic [1:0]                  cp_fast;
  logic [1:0][4:0]             cp_fast_mult;
  logic [1:0]                  fl_pin_out;
  logic [1:0]                  fl_pin_oe_n;
  int                          num_errors;
  int                          compares;
  logic [7:0]                  q;
  logic [9:0]                  win_hn [8] = '{10'h00E, 10'h014, 10'h01E, 10'h028,
                                              10'h03C, 10'h064, 10'h08C, 10'h0C8};
  logic [15:0]                 fl_word [5] = '{16'h1009, 16'h120E, 16'h1003,
                                               16'h1404, 16'h1E04};
  int                          fl_len [5] = '{2, 12, 128, 16, 16384};
  logic [4:0]                  fl_mult [5] = '{5'h08, 5'h0C, 5'h10, 5'h04, 5'h04};

  // clock at 125 MHz
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  // host model and design
  slfl_host host (.clk_sys(clk_sys), .rd_data(rd_data), .wr_en(wr_en),
                  .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr));
  slfl_top #(.NSYN(2)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .pd_cmp(pd_cmp), .div_update(div_update), .lock(lock),
    .det_pwr_en(det_pwr_en), .cp_fast(cp_fast), .cp_fast_mult(cp_fast_mult),
    .fl_pin_out(fl_pin_out), .fl_pin_oe_n(fl_pin_oe_n));

  // ************************************************
  // helpers
  // ************************************************
  // verdict and end of run
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // cut a hang short
  task automatic guard(input int n, input int lim);
    if (n > lim) begin
      num_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      complete_run();
    end
  endtask

  // n back-to-back comparisons with one difference
  task automatic cmp_n(input int s, input int n, input logic [9:0] d);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      pd_cmp[s] = {1'b1, d};
    end
    @(negedge clk_sys);
    pd_cmp[s] = {1'b0, d};
  endtask

  // cycles until lock reaches a level
  task automatic wait_lock(input int s, input logic v, output int n);
    n = 0;
    while (lock[s] !== v) begin
      @(negedge clk_sys);
      n++;
      guard(n, 1000);
    end
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_reset();
    `CHK(lock, 2'b00, "lock at reset")
    `CHK(det_pwr_en, 2'b00, "detector at reset")
    `CHK(cp_fast, 2'b00, "fast at reset")
    `CHK(fl_pin_oe_n, 2'b11, "pin at reset")
    `CHK(fl_pin_out, 2'b00, "pin level")
    `CHK(cp_fast_mult[0], 5'h04, "mult at reset")
    host.rd(slfl_pkg::ADDR_ST1, q);
    `CHK(q, 8'h00, "status at reset")
  endtask

  // every lock window code, loss codes in turn, thresholds of one
  task automatic t_windows(input int s);
    logic [9:0] w;
    logic [9:0] b;
    for (int c = 0; c < 8; c++) begin
      w = win_hn[c];
      b = 10'((int'(w) * (2 + c % 3)) / 2);
      host.wr_ld(s, 16'h8021 | 16'((c % 3) << 11) | 16'(c << 8));
      `CHK(det_pwr_en[s], 1'b1, "detector on")
      cmp_n(s, 1, w + 10'h001);
      `CHK(lock[s], 1'b0, "outside lock window")
      cmp_n(s, 1, w);
      `CHK(lock[s], 1'b1, "inside lock window")
      `CHK(lock[1 - s], 1'b0, "other synth lock")
      cmp_n(s, 1, b);
      `CHK(lock[s], 1'b1, "inside loss window")
      cmp_n(s, 1, b + 10'h001);
      `CHK(lock[s], 1'b0, "outside loss window")
    end
  endtask

  // broken runs restart counting, status flags follow
  task automatic t_runs(input int s);
    logic [7:0] st;
    st = s ? slfl_pkg::ADDR_ST2 : slfl_pkg::ADDR_ST1;
    host.wr_ld(s, 16'h8843);
    host.rd(st, q);
    cmp_n(s, 2, 10'h00E);
    cmp_n(s, 1, 10'h00F);
    cmp_n(s, 2, 10'h000);
    `CHK(lock[s], 1'b0, "lock run broken")
    cmp_n(s, 1, 10'h005);
    `CHK(lock[s], 1'b1, "lock after three")
    host.wr(8'h51, 16'hFFFF);
    host.rd(8'h57, q);
    `CHK(q, 8'h00, "unmapped read")
    host.rd(st, q);
    `CHK(q, 8'h82, "status locked")
    cmp_n(s, 1, 10'h016);
    cmp_n(s, 1, 10'h015);
    cmp_n(s, 1, 10'h016);
    `CHK(lock[s], 1'b1, "loss run broken")
    cmp_n(s, 1, 10'h3FF);
    `CHK(lock[s], 1'b0, "lock lost after two")
    host.rd(st, q);
    `CHK(q, 8'h01, "status lost")
  endtask

  // zero threshold codes mean 32 and 8
  task automatic t_zero();
    host.wr_ld(0, 16'h8000);
    cmp_n(0, 31, 10'h000);
    `CHK(lock[0], 1'b0, "31 hits")
    cmp_n(0, 1, 10'h000);
    `CHK(lock[0], 1'b1, "32 hits")
    cmp_n(0, 7, 10'h3FF);
    `CHK(lock[0], 1'b1, "7 misses")
    cmp_n(0, 1, 10'h3FF);
    `CHK(lock[0], 1'b0, "8 misses")
  endtask

  // reset-lock pulse, then disable
  task automatic t_rstlock();
    host.wr_ld(0, 16'h8001);
    cmp_n(0, 1, 10'h000);
    `CHK(lock[0], 1'b1, "locked before reset")
    host.wr_ld(0, 16'hA001);
    repeat (2) @(negedge clk_sys);
    `CHK(lock[0], 1'b0, "reset lock")
    host.rd(slfl_pkg::ADDR_ST1, q);
    `CHK(q, 8'h00, "flags cleared")
    cmp_n(0, 1, 10'h000);
    `CHK(lock[0], 1'b1, "detection resumes")
    host.wr_ld(0, 16'h0001);
    `CHK(det_pwr_en[0], 1'b0, "detector off")
    cmp_n(0, 3, 10'h000);
    `CHK(lock[0], 1'b0, "no lock when off")
  endtask

  // analogue charge 5 us, discharge 5x
  task automatic t_analogue();
    int n;
    host.wr_ld(0, 16'hC000);
    cmp_n(0, 1, 10'h000);
    wait_lock(0, 1'b1, n);
    `CHK(n inside {[600:640]}, 1'b1, "charge time")
    cmp_n(0, 1, 10'h3FF);
    wait_lock(0, 1'b0, n);
    `CHK(n inside {[110:140]}, 1'b1, "discharge time")
  endtask

  // fastlock lengths, multipliers, disabled update
  task automatic t_fast(input int s);
    int n;
    for (int k = 0; k < 6; k++) begin
      host.wr_fl(s, k < 5 ? fl_word[k] : 16'h0009);
      @(negedge clk_sys);
      div_update[s] = 1'b1;
      @(negedge clk_sys);
      div_update[s] = 1'b0;
      `CHK(cp_fast[1 - s], 1'b0, "other synth idle")
      if (k == 5) begin
        `CHK({cp_fast[s], fl_pin_oe_n[s]}, 2'b01, "update ignored")
      end else begin
        `CHK({cp_fast[s], fl_pin_oe_n[s]}, 2'b10, "fastlock start")
        `CHK(cp_fast_mult[s], fl_mult[k], "fast multiplier")
        n = 0;
        while (cp_fast[s] === 1'b1 && fl_pin_oe_n[s] === 1'b0) begin
          @(negedge clk_sys);
          n++;
          guard(n, 20000);
        end
        `CHK(n, fl_len[k], "fastlock length")
        `CHK({cp_fast[s], fl_pin_oe_n[s]}, 2'b01, "pin released")
      end
    end
  endtask

  // main sequence
  initial begin
    rst_n      = 1'b0;
    div_update = 2'b00;
    pd_cmp     = '0;
    num_errors = 0;
    compares   = 0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_windows(0);
    t_windows(1);
    t_runs(0);
    t_runs(1);
    t_zero();
    t_rstlock();
    t_analogue();
    t_fast(0);
    t_fast(1);
    complete_run();
  end
endmodule
